// ### dcs_sequencer.sv
// Device-side DDR command sequencer: banks, bursts, power modes
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Precharge cutting a length-4 write stops strobe and data sampling.
// - Precharge closes one bank if auto-precharge bit low, else all.
// - Power-down is precharge type if all idle, else active type.
// - Mask never driven; data and strobe driven only in read bursts, which row commands and auto refresh leave running.
// - Write without auto precharge leaves the row open.
// - A read may cut a write burst, even to another bank.
// - Length-4 read returns three more elements in programmed order.
module dcs_sequencer #(
  parameter int COL_W = 6               // Stored column bits per bank
) (
  input  wire logic                       ref_clk,      // Device clock
  input  wire logic                       rst_n,        // Async reset
  input  wire logic                       cke,          // Clock enable pin
  input  wire logic                       cs_n,         // Chip select
  input  wire logic                       ras_n,        // Row strobe
  input  wire logic                       cas_n,        // Column strobe
  input  wire logic                       we_n,         // Write enable
  input  wire logic [1:0]                 ba,           // Bank address
  input  wire logic [dcs_pkg::ADDR_W-1:0] addr,         // Row/col address
  input  wire logic                       lower_byte_write_mask, // Mask lo
  input  wire logic                       upper_byte_write_mask, // Mask hi
  input  wire logic [dcs_pkg::DQ_W-1:0]   dq_in,        // Data pin in
  output logic      [dcs_pkg::DQ_W-1:0]   dq_out,       // Data pin out
  output logic                            dq_oe,        // Data pin enable
  input  wire logic                       dqs_in,       // Strobe pin in
  output logic                            dqs_out,      // Strobe pin out
  output logic                            dqs_oe,       // Strobe enable
  output logic      [3:0]                 rows_open,    // Open-row flags
  output logic                            precharge_pd, // In precharge PD
  output logic                            active_pd,    // In active PD
  output logic                            self_refresh  // In self refresh
);
  localparam int MEM_W = 2 + COL_W;
  // Storage index needs the three burst bits; wider columns cost memory
  if (COL_W < 3 || COL_W > 10) begin : g_bad_col_w
    $error("dcs_sequencer: bad COL_W");
  end

  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------
  logic [3:0] cmd;
  logic       ap_bit;
  assign cmd    = {cs_n, ras_n, cas_n, we_n};
  assign ap_bit = addr[dcs_pkg::AP_BIT];

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  dcs_pkg::dcs_pwr_t   pwr_reg, pwr_next;
  dcs_pkg::dcs_burst_t bs_reg, bs_next;
  logic [2:0]       bl_code_reg, bl_code_next;
  logic             btype_reg, btype_next;
  logic [2:0]       cl_reg, cl_next;
  logic [3:0]       open_reg, open_next;
  logic [2:0]       cnt_reg, cnt_next;
  logic [2:0]       wait_reg, wait_next;
  logic [1:0]       bbank_reg, bbank_next;
  logic [COL_W-1:0] bcol_reg, bcol_next;
  logic             bap_reg, bap_next;
  logic             cke_prev_reg;
  logic [dcs_pkg::DQ_W-1:0] dq_out_reg, dq_out_next;
  logic             dq_oe_reg, dq_oe_next;
  logic             dqs_reg, dqs_next;

  logic [dcs_pkg::DQ_W-1:0] mem [0:(1<<MEM_W)-1];

  // ---------------------------------------------------------------
  // Burst addressing
  // ---------------------------------------------------------------
  logic [2:0]       len_mask;
  logic [2:0]       elem_col;
  logic [MEM_W-1:0] elem_addr;
  logic             last_elem;
  always_comb begin
    unique case (bl_code_reg)
      dcs_pkg::BL_CODE_2: len_mask = dcs_pkg::BL_MASK_2;
      dcs_pkg::BL_CODE_8: len_mask = dcs_pkg::BL_MASK_8;
      default:            len_mask = dcs_pkg::BL_MASK_4;
    endcase
  end
  dcs_burst_order u_order (
    .start_col  (bcol_reg[2:0]),
    .elem_idx   (cnt_reg),
    .len_mask   (len_mask),
    .interleave (btype_reg),
    .col_out    (elem_col)
  );
  assign elem_addr = {bbank_reg, bcol_reg[COL_W-1:3], elem_col};
  assign last_elem = (cnt_reg == len_mask);

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  logic mem_we;
  logic run_cmd;
  always_comb begin
    pwr_next     = pwr_reg;
    bs_next      = bs_reg;
    bl_code_next = bl_code_reg;
    btype_next   = btype_reg;
    cl_next      = cl_reg;
    open_next    = open_reg;
    cnt_next     = cnt_reg;
    wait_next    = wait_reg;
    bbank_next   = bbank_reg;
    bcol_next    = bcol_reg;
    bap_next     = bap_reg;
    dq_out_next  = dq_out_reg;
    dq_oe_next   = 1'b0;        // Pins float unless a read drives
    dqs_next     = 1'b0;
    mem_we       = 1'b0;
    run_cmd      = (pwr_reg == dcs_pkg::PWR_RUN) && cke_prev_reg && cke;

    // Burst engine first; a fresh command below overrides it
    unique case (bs_reg)
      dcs_pkg::BS_IDLE: ;
      dcs_pkg::BS_READ_WAIT: begin
        wait_next = wait_reg - 3'h1;
        if (wait_reg == 3'h1) begin
          bs_next  = dcs_pkg::BS_READ;
          cnt_next = 3'h0;
        end
      end
      dcs_pkg::BS_READ: begin
        dq_out_next = mem[elem_addr];
        dq_oe_next  = 1'b1;
        dqs_next    = ~cnt_reg[0];
        cnt_next    = cnt_reg + 3'h1;
        if (last_elem) begin
          bs_next = dcs_pkg::BS_IDLE;
          if (bap_reg) open_next[bbank_reg] = 1'b0;
        end
      end
      dcs_pkg::BS_WRITE: begin
        mem_we   = 1'b1;
        cnt_next = cnt_reg + 3'h1;
        if (last_elem) begin
          bs_next = dcs_pkg::BS_IDLE;
          // Row stays open unless auto precharge was asked for
          if (bap_reg) open_next[bbank_reg] = 1'b0;
        end
      end
    endcase

    if (run_cmd) begin
      unique case (cmd)
        dcs_pkg::CMD_MRS: begin
          if (ba == dcs_pkg::MR_BANK) begin
            bl_code_next = addr[dcs_pkg::MR_BL_LSB +: 3];
            btype_next   = addr[dcs_pkg::MR_BT_BIT];
            cl_next      = addr[dcs_pkg::MR_CL_LSB +: 3];
          end
        end
        dcs_pkg::CMD_ACT: open_next[ba] = 1'b1;
        dcs_pkg::CMD_READ, dcs_pkg::CMD_WRITE: begin
          // A new column command cuts any burst, any bank
          bbank_next = ba;
          bcol_next  = addr[COL_W-1:0];
          bap_next   = ap_bit;
          cnt_next   = 3'h0;
          if (cmd == dcs_pkg::CMD_WRITE) begin
            bs_next = dcs_pkg::BS_WRITE;
          end else begin
            bs_next   = dcs_pkg::BS_READ_WAIT;
            wait_next = cl_reg - 3'h1;
          end
        end
        dcs_pkg::CMD_BST: begin
          if (bs_reg != dcs_pkg::BS_WRITE) bs_next = dcs_pkg::BS_IDLE;
        end
        dcs_pkg::CMD_PRE: begin
          if (ap_bit) open_next = 4'h0;
          else        open_next[ba] = 1'b0;
          // Cut write: strobe and data are no longer sampled
          if (bs_reg == dcs_pkg::BS_WRITE) bs_next = dcs_pkg::BS_IDLE;
        end
        default: ;
      endcase
    end

    // Power modes follow the clock-enable pin
    unique case (pwr_reg)
      dcs_pkg::PWR_RUN: begin
        if (cke_prev_reg && !cke) begin
          if (cmd == dcs_pkg::CMD_REF) begin
            pwr_next = dcs_pkg::PWR_SELF_REFRESH;  // Banks idle
          end else if (open_next == 4'h0) begin
            pwr_next = dcs_pkg::PWR_PRECHARGE_PD;
          end else begin
            pwr_next = dcs_pkg::PWR_ACTIVE_PD;
          end
          // No column access may be running here
          bs_next    = dcs_pkg::BS_IDLE;
          // An aborted read must not keep the pins driven
          dq_oe_next = 1'b0;
          dqs_next   = 1'b0;
        end
      end
      dcs_pkg::PWR_PRECHARGE_PD, dcs_pkg::PWR_ACTIVE_PD,
      dcs_pkg::PWR_SELF_REFRESH: begin
        if (cke) pwr_next = dcs_pkg::PWR_RUN;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_reg      <= dcs_pkg::PWR_RUN;
      bs_reg       <= dcs_pkg::BS_IDLE;
      bl_code_reg  <= dcs_pkg::BL_RESET;
      btype_reg    <= 1'b0;
      cl_reg       <= dcs_pkg::CL_RESET;
      open_reg     <= 4'h0;
      cnt_reg      <= 3'h0;
      wait_reg     <= 3'h0;
      bbank_reg    <= 2'h0;
      bcol_reg     <= '0;
      bap_reg      <= 1'b0;
      cke_prev_reg <= 1'b0;
      dq_out_reg   <= '0;
      dq_oe_reg    <= 1'b0;
      dqs_reg      <= 1'b0;
    end else begin
      pwr_reg      <= pwr_next;
      bs_reg       <= bs_next;
      bl_code_reg  <= bl_code_next;
      btype_reg    <= btype_next;
      cl_reg       <= cl_next;
      open_reg     <= open_next;
      cnt_reg      <= cnt_next;
      wait_reg     <= wait_next;
      bbank_reg    <= bbank_next;
      bcol_reg     <= bcol_next;
      bap_reg      <= bap_next;
      cke_prev_reg <= cke;
      dq_out_reg   <= dq_out_next;
      dq_oe_reg    <= dq_oe_next;
      dqs_reg      <= dqs_next;
    end
  end

  // Storage has no reset; masked bytes keep their old contents
  always_ff @(posedge ref_clk) begin
    if (mem_we && !lower_byte_write_mask)
      mem[elem_addr][7:0] <= dq_in[7:0];
    if (mem_we && !upper_byte_write_mask)
      mem[elem_addr][15:8] <= dq_in[15:8];
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign dq_out       = dq_out_reg;
  assign dq_oe        = dq_oe_reg;
  assign dqs_out      = dqs_reg;
  assign dqs_oe       = dq_oe_reg;
  assign rows_open    = open_reg;
  assign precharge_pd = (pwr_reg == dcs_pkg::PWR_PRECHARGE_PD);
  assign active_pd    = (pwr_reg == dcs_pkg::PWR_ACTIVE_PD);
  assign self_refresh = (pwr_reg == dcs_pkg::PWR_SELF_REFRESH);

  // Strobe input is accepted but data is taken on the clock in this model
  logic unused_dqs;
  assign unused_dqs = dqs_in;
endmodule // dcs_sequencer
`default_nettype wire

// ### dcs_pkg.sv
// Shared constants for the DDR device-side command sequencer
package dcs_pkg;
  // ---------------------------------------------------------------
  // Command encodings {cs_n, ras_n, cas_n, we_n}
  // ---------------------------------------------------------------
  localparam logic [3:0] CMD_MRS   = 4'h0;
  localparam logic [3:0] CMD_REF   = 4'h1;
  localparam logic [3:0] CMD_PRE   = 4'h2;
  localparam logic [3:0] CMD_ACT   = 4'h3;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_READ  = 4'h5;
  localparam logic [3:0] CMD_BST   = 4'h6;
  // ---------------------------------------------------------------
  // Mode register fields (written by MRS with bank address 0)
  // ---------------------------------------------------------------
  localparam int          MR_BL_LSB   = 0;
  localparam int          MR_BT_BIT   = 3;
  localparam int          MR_CL_LSB   = 4;
  localparam int          AP_BIT      = 10;
  localparam logic [1:0]  MR_BANK     = 2'h0;
  localparam logic [2:0]  BL_CODE_2   = 3'h1;
  localparam logic [2:0]  BL_CODE_4   = 3'h2;
  localparam logic [2:0]  BL_CODE_8   = 3'h3;
  localparam logic [2:0]  BL_RESET    = 3'h2;
  localparam logic [2:0]  CL_RESET    = 3'h2;
  localparam logic [2:0]  CL_MIN      = 3'h2;
  localparam logic [2:0]  CL_MAX      = 3'h4;
  localparam logic [2:0]  BL_MASK_2   = 3'h1;
  localparam logic [2:0]  BL_MASK_4   = 3'h3;
  localparam logic [2:0]  BL_MASK_8   = 3'h7;
  localparam int          NUM_BANKS   = 4;
  localparam int          DQ_W        = 16;
  localparam int          ADDR_W      = 12;
  // ---------------------------------------------------------------
  // States
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PWR_RUN, PWR_PRECHARGE_PD, PWR_ACTIVE_PD, PWR_SELF_REFRESH
  } dcs_pwr_t;
  typedef enum logic [1:0] {
    BS_IDLE, BS_READ_WAIT, BS_READ, BS_WRITE
  } dcs_burst_t;
endpackage

// ### dcs_burst_order.sv
// Column offset of one burst element in sequential or interleaved order
`timescale 1ns/1ps
`default_nettype none
module dcs_burst_order (
  input  wire logic [2:0] start_col,  // Low column bits of the access
  input  wire logic [2:0] elem_idx,   // Element number within burst
  input  wire logic [2:0] len_mask,   // Burst length minus one
  input  wire logic       interleave, // 1 = interleaved order
  output logic      [2:0] col_out     // Low column bits of the element
);
  logic [2:0] wrap;
  always_comb begin
    wrap = interleave ? (start_col ^ elem_idx) : (start_col + elem_idx);
    // Only the bits inside the burst wrap; upper bits stay put
    col_out = (start_col & ~len_mask) | (wrap & len_mask);
  end
endmodule // dcs_burst_order
`default_nettype wire

// ### dcs_seq_assertions.sv
// Pin-level checks for the DDR command sequencer
`timescale 1ns/1ps
`default_nettype none
module dcs_seq_assertions (
  input wire logic                       ref_clk,      // Clock
  input wire logic                       rst_n,        // Reset
  input wire logic                       cke,          // Clock enable
  input wire logic                       cs_n,         // Select
  input wire logic                       ras_n,        // Row strobe
  input wire logic                       cas_n,        // Column strobe
  input wire logic                       we_n,         // Write enable
  input wire logic [1:0]                 ba,           // Bank
  input wire logic [dcs_pkg::ADDR_W-1:0] addr,         // Address
  input wire logic                       dq_oe,        // Data enable
  input wire logic                       dqs_oe,       // Strobe enable
  input wire logic                       dqs_out,      // Strobe
  input wire logic [3:0]                 rows_open,    // Open rows
  input wire logic                       precharge_pd, // Precharge PD
  input wire logic                       active_pd,    // Active PD
  input wire logic                       self_refresh  // Self refresh
);
  logic       cke_q;
  logic [3:0] cmd;
  logic       low;
  logic       take;
  assign cmd  = {cs_n, ras_n, cas_n, we_n};
  assign low  = precharge_pd | active_pd | self_refresh;
  // A command counts only with cke high on this edge and the one before
  assign take = cke & cke_q & ~low;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) cke_q <= 1'b0;
    else cke_q <= cke;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_rd; take && cmd == dcs_pkg::CMD_READ; endsequence
  // Four elements, strobe high on the even ones, then release
  sequence s_burst;
    (dq_oe & dqs_out) ##1 (dq_oe & !dqs_out) ##1 (dq_oe & dqs_out)
    ##1 (dq_oe & !dqs_out) ##1 !dq_oe;
  endsequence
  property p_rd_burst; s_rd |-> ##3 s_burst; endproperty
  sequence s_wr_na; take && cmd == dcs_pkg::CMD_WRITE &&
    !addr[dcs_pkg::AP_BIT]; endsequence
  // Once a length-4 write is over its row is still open, unless precharged
  sequence s_no_pre; (!(take && cmd == dcs_pkg::CMD_PRE))[*5]; endsequence
  property p_pre_one; take && cmd == dcs_pkg::CMD_PRE &&
    !addr[dcs_pkg::AP_BIT] |=> !rows_open[$past(ba)]; endproperty
  property p_pre_all; take && cmd == dcs_pkg::CMD_PRE &&
    addr[dcs_pkg::AP_BIT] |=> rows_open == 4'h0; endproperty
  property p_wr_open; s_wr_na ##1 s_no_pre |-> rows_open[$past(ba, 5)];
  endproperty
  property p_pd_in; cke_q && !cke && !low && cmd != dcs_pkg::CMD_REF
    |-> ##[1:2] (precharge_pd | active_pd); endproperty
  property p_pd_pre; precharge_pd |-> rows_open == 4'h0; endproperty
  property p_pd_act; active_pd |-> rows_open != 4'h0; endproperty
  property p_quiet; low |-> !dq_oe && !dqs_oe; endproperty
  a_rd_burst: assert property (p_rd_burst)
    else $error("read burst shape wrong");
  a_pre_one: assert property (p_pre_one)
    else $error("single-bank precharge left bank open");
  a_pre_all: assert property (p_pre_all)
    else $error("all-bank precharge left a row open");
  a_wr_open: assert property (p_wr_open)
    else $error("write without auto precharge closed the row");
  a_pd_in: assert property (p_pd_in)
    else $error("power-down not entered");
  a_pd_pre: assert property (p_pd_pre)
    else $error("precharge power-down with rows open");
  a_pd_act: assert property (p_pd_act)
    else $error("active power-down with no row open");
  a_quiet: assert property (p_quiet)
    else $error("data pins driven in low-power state");
endmodule // dcs_seq_assertions
bind dcs_sequencer dcs_seq_assertions dcs_seq_assertions_i (.ref_clk,
  .rst_n, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr, .dq_oe, .dqs_oe,
  .dqs_out, .rows_open, .precharge_pd, .active_pd, .self_refresh);
`default_nettype wire

// ### dcs_ctrl_model.sv
// Controller-side pin driver facing the DDR command sequencer
`timescale 1ns/1ps
`default_nettype none
module dcs_ctrl_model (
  input  wire logic        ref_clk,  // Clock
  input  wire logic        rst_n,    // Reset
  input  wire logic [3:0]  req_cmd,  // Command code
  input  wire logic [1:0]  req_ba,   // Bank
  input  wire logic [11:0] req_addr, // Address
  input  wire logic        req_cke,  // Clock enable
  input  wire logic        req_dv,   // Data valid
  input  wire logic [15:0] req_dq,   // Write data
  output logic             cke,      // Pin
  output logic [3:0]       cmd,      // Select, row, column, write
  output logic [1:0]       ba,       // Pin
  output logic [11:0]      addr,     // Pin
  output logic [15:0]      dq,       // Pin
  output logic             dqs       // Pin
);
  // Pins move just after an edge; idle data never repeats the last word
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cke  <= 1'b0;
      cmd  <= 4'hF;
      ba   <= 2'h0;
      addr <= 12'h000;
      dq   <= 16'h0000;
      dqs  <= 1'b0;
    end else begin
      cke  <= req_cke;
      cmd  <= req_cmd;
      ba   <= req_ba;
      addr <= req_addr;
      dq   <= req_dv ? req_dq : ~dq;
      dqs  <= req_dv & ~dqs;
    end
  end
endmodule // dcs_ctrl_model
`default_nettype wire

// ### test_dcs_sequencer.sv
// Self-checking bench for the DDR command sequencer
`timescale 1ns/1ps
`default_nettype none
module test_dcs_sequencer;
  logic        ref_clk, rst_n, req_cke, req_dv, cke, dqs;
  logic        dq_oe, dqs_out, dqs_oe, ppd, apd, sr;
  logic [3:0]  req_cmd, cmd, rows_open;
  logic [1:0]  req_ba, ba;
  logic [11:0] req_addr, addr;
  logic [15:0] req_dq, dq, dq_out, rnd;
  logic [15:0] mem [0:3];
  logic [15:0] expq [$];
  int          error_cnt = 0;
  int          num_checks = 0;
  dcs_ctrl_model dcs_ctrl_model_i (.ref_clk, .rst_n, .req_cmd, .req_ba,
    .req_addr, .req_cke, .req_dv, .req_dq, .cke, .cmd, .ba, .addr, .dq,
    .dqs);
  dcs_sequencer dcs_sequencer_i (.ref_clk, .rst_n, .cke, .cs_n(cmd[3]),
    .ras_n(cmd[2]), .cas_n(cmd[1]), .we_n(cmd[0]), .ba, .addr,
    .lower_byte_write_mask(1'b0), .upper_byte_write_mask(1'b0),
    .dq_in(dq), .dq_out, .dq_oe, .dqs_in(dqs), .dqs_out, .dqs_oe,
    .rows_open, .precharge_pd(ppd), .active_pd(apd), .self_refresh(sr));
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk_stat(input string n, input logic [3:0] e, g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_data(input logic [15:0] e, g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR dq_out expected %h seen %h", e, g);
    end
  endtask
  task automatic final_report;
    if (error_cnt == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic issue(input logic [3:0] c, input logic [1:0] b,
                       input logic [11:0] a, input logic k);
    @(posedge ref_clk);
    req_cmd  <= c;
    req_ba   <= b;
    req_addr <= a;
    req_cke  <= k;
    @(posedge ref_clk);
    req_cmd  <= 4'hF;
  endtask
  task automatic push(input logic [1:0] s, input logic il);
    for (int i = 0; i < 4; i++)
      expq.push_back(mem[il ? (s ^ i[1:0]) : (s + i[1:0])]);
  endtask
  // Burst to column 0 of bank 0; cutc cuts it after two words (F = none)
  task automatic wr(input int n, input logic [3:0] cutc);
    issue(dcs_pkg::CMD_WRITE, 2'h0, 12'h000, 1'b1);
    for (int i = 0; i < n; i++) begin
      if (i > 0) @(posedge ref_clk);
      rnd = lfsr(rnd);
      if (cutc == 4'hF || i < 2) mem[i] = rnd;
      req_dv <= 1'b1;
      req_dq <= rnd;
      if (i > 0) req_cmd <= (i == 1) ? cutc : 4'hF;
    end
    @(posedge ref_clk);
    req_dv  <= 1'b0;
    req_cmd <= 4'hF;
    if (cutc == dcs_pkg::CMD_READ) push(2'h0, 1'b0);
  endtask
  task automatic see(input logic [3:0] r, p);
    repeat (4) @(posedge ref_clk);
    #1;
    chk_stat("rows_open", r, rows_open);
    chk_stat("power", p, {1'b0, ppd, apd, sr});
  endtask
  always @(negedge ref_clk) begin
    if (dq_oe === 1'b1) begin
      if (expq.size() > 0) chk_data(expq.pop_front(), dq_out);
      else chk_stat("dq_oe", 4'h0, 4'h1);
    end
  end
  initial begin
    repeat (3000) @(posedge ref_clk);
    error_cnt++;
    final_report();
  end
  initial begin
    rst_n = 1'b0;
    req_cke = 1'b1;
    req_dv = 1'b0;
    req_cmd = 4'hF;
    req_ba = 2'h0;
    req_addr = 12'h000;
    req_dq = 16'h0000;
    rnd = 16'h0031;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    issue(dcs_pkg::CMD_MRS, dcs_pkg::MR_BANK, 12'h022, 1'b1);
    repeat (200) @(posedge ref_clk);
    issue(dcs_pkg::CMD_ACT, 2'h0, rnd[11:0], 1'b1);
    issue(dcs_pkg::CMD_ACT, 2'h1, rnd[11:0], 1'b1);
    see(4'h3, 4'h0);
    wr(4, 4'hF);
    see(4'h3, 4'h0);
    issue(dcs_pkg::CMD_READ, 2'h0, 12'h001, 1'b1);
    push(2'h1, 1'b0);
    repeat (10) @(posedge ref_clk);
    // Same start column in interleaved order wraps differently
    issue(dcs_pkg::CMD_MRS, dcs_pkg::MR_BANK, 12'h02A, 1'b1);
    repeat (2) @(posedge ref_clk);
    issue(dcs_pkg::CMD_READ, 2'h0, 12'h001, 1'b1);
    push(2'h1, 1'b1);
    repeat (10) @(posedge ref_clk);
    issue(dcs_pkg::CMD_MRS, dcs_pkg::MR_BANK, 12'h022, 1'b1);
    repeat (2) @(posedge ref_clk);
    wr(2, dcs_pkg::CMD_READ);
    repeat (10) @(posedge ref_clk);
    issue(dcs_pkg::CMD_PRE, 2'h1, 12'h000, 1'b1);
    see(4'h1, 4'h0);
    issue(dcs_pkg::CMD_ACT, 2'h1, rnd[11:0], 1'b1);
    issue(dcs_pkg::CMD_PRE, 2'h1, 12'h400, 1'b1);
    see(4'h0, 4'h0);
    // A precharge cutting the write keeps the old words in columns 2 and 3
    issue(dcs_pkg::CMD_ACT, 2'h0, rnd[11:0], 1'b1);
    repeat (3) @(posedge ref_clk);
    wr(4, dcs_pkg::CMD_PRE);
    see(4'h0, 4'h0);
    issue(dcs_pkg::CMD_ACT, 2'h0, rnd[11:0], 1'b1);
    repeat (3) @(posedge ref_clk);
    issue(dcs_pkg::CMD_READ, 2'h0, 12'h400, 1'b1);
    push(2'h0, 1'b0);
    repeat (6) @(posedge ref_clk);
    see(4'h0, 4'h0);
    issue(dcs_pkg::CMD_ACT, 2'h2, rnd[11:0], 1'b1);
    issue(4'hF, 2'h0, 12'h000, 1'b0);
    see(4'h4, 4'h2);
    issue(4'hF, 2'h0, 12'h000, 1'b1);
    issue(dcs_pkg::CMD_PRE, 2'h0, 12'h400, 1'b1);
    issue(4'hF, 2'h0, 12'h000, 1'b0);
    see(4'h0, 4'h4);
    issue(4'hF, 2'h0, 12'h000, 1'b1);
    issue(dcs_pkg::CMD_REF, 2'h0, 12'h000, 1'b0);
    see(4'h0, 4'h1);
    issue(4'hF, 2'h0, 12'h000, 1'b1);
    repeat (200) @(posedge ref_clk);
    see(4'h0, 4'h0);
    chk_stat("pending reads", 4'h0, 4'(expq.size()));
    final_report();
  end
endmodule // test_dcs_sequencer
`default_nettype wire
